// [core/dct_core.sv]
// Contract
// - Shared divider: /12, /4, /48, external /8
// - Clock-select bit: system clock or prescaled clock
// - Export four selects to auto-reload timers
// - Count is 16 bits as two bytes
// - 13-bit mode: high byte, low five bits
// - 13-bit wrap sets flag and requests interrupt
// - Counter select counts falling pin edges
// - Run bit and optional gate input enable counting
// - Setting run never clears the count
// - Second timer mirrors first with own inputs
// - 16-bit mode uses all sixteen bits
// - Reload mode copies high byte on wrap
// - Split low byte uses first timer controls
// - Split high byte: internal clock, second run
// - Split: second timer no pin, no flag
// - Split: second timer stops in mode three
// - Interrupt request equals flag and enable
// - Timers configured independently
// - Mode codes 00,01,10,11
// - Flag cleared by vector or software
`timescale 1ns/1ps
`default_nettype none

module dct_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        meta_reg <= d;
        q        <= meta_reg;
    end
endmodule

module dct_core
    import dct_pkg::*;
(
    input  wire logic                     MCLK,
    input  wire logic                     RST,
    input  wire dct_pkg::dct_sfr_req_type SFR_REQ,
    output var  logic [7:0]               SFR_RDATA,
    input  wire logic                     FIRST_EVENT_PIN,
    input  wire logic                     SECOND_EVENT_PIN,
    input  wire logic                     FIRST_EXT_IRQ_INPUT,
    input  wire logic                     SECOND_EXT_IRQ_INPUT,
    input  wire logic                     FIRST_IRQ_POLARITY,
    input  wire logic                     SECOND_IRQ_POLARITY,
    input  wire logic                     FIRST_TIMER_IRQ_ENABLE,
    input  wire logic                     SECOND_TIMER_IRQ_ENABLE,
    input  wire logic                     FIRST_IRQ_ACK,
    input  wire logic                     SECOND_IRQ_ACK,
    input  wire logic                     EXT_OSC_CLK,
    output var  logic                     FIRST_TIMER_IRQ,
    output var  logic                     SECOND_TIMER_IRQ,
    output var  logic                     SECOND_TIMER_OVF_PULSE,
    output var  logic                     TIMER3_HIGH_SYSCLK_SELECT,
    output var  logic                     TIMER3_LOW_SYSCLK_SELECT,
    output var  logic                     TIMER2_HIGH_SYSCLK_SELECT,
    output var  logic                     TIMER2_LOW_SYSCLK_SELECT
);
    import dct_pkg::*;

    // ==========================================================
    // Register state
    // ==========================================================
    logic [7:0]    timer_clock_control_reg;
    logic [7:0]    timer_mode_reg_reg;
    logic          tr0_reg, tr1_reg, tf0_reg, tf1_reg;
    logic          tf0_next, tf1_next;
    logic [7:0]    tl0_reg, th0_reg, tl1_reg, th1_reg;
    logic [5:0]    pre_cnt_reg;
    logic [2:0]    ext_cnt_reg;
    logic [4:0]    sync_q;
    logic [4:0]    sync_prev_reg;
    logic          wr_timer_control_reg, wr_timer_mode_reg, wr_timer_clock_control, wr_tl0, wr_th0, wr_tl1, wr_th1;
    logic [5:0]    pre_lim;
    logic          pre_tick, ext_rise;
    logic          ev0_fall, ev1_fall, first_ext_irq_input_act, second_ext_irq_input_act;
    logic          split, t0_run, t1_run, t0_inc, t1_inc, th0_inc;
    logic          t0_set, t1_set, t1_ovf;
    dct_mode_type  mode0, mode1;
    dct_presc_type sca;
    dct_count_type step0, step1;

    assign wr_timer_control_reg  = SFR_REQ.wr && SFR_REQ.addr == ADDR_TIMER_CONTROL;
    assign wr_timer_mode_reg  = SFR_REQ.wr && SFR_REQ.addr == ADDR_TIMER_MODE;
    assign wr_timer_clock_control = SFR_REQ.wr && SFR_REQ.addr == ADDR_CLOCK_CONTROL;
    assign wr_tl0   = SFR_REQ.wr && SFR_REQ.addr == ADDR_FIRST_LOW;
    assign wr_th0   = SFR_REQ.wr && SFR_REQ.addr == ADDR_FIRST_HIGH;
    assign wr_tl1   = SFR_REQ.wr && SFR_REQ.addr == ADDR_SECOND_LOW;
    assign wr_th1   = SFR_REQ.wr && SFR_REQ.addr == ADDR_SECOND_HIGH;

    assign mode0 = dct_mode_type'(timer_mode_reg_reg[TM_FIRST_MODE+:2]);
    assign mode1 = dct_mode_type'(timer_mode_reg_reg[TM_SECOND_MODE+:2]);
    assign sca   = dct_presc_type'(timer_clock_control_reg[CK_DIV_LSB+:2]);
    assign split = mode0 == MODE_SPLIT;

    // ==========================================================
    // Input synchronisers and edge detect
    // ==========================================================
    dct_sync #(.W(5)) u_sync (
        .clk (MCLK),
        .d   ({EXT_OSC_CLK, SECOND_EXT_IRQ_INPUT, FIRST_EXT_IRQ_INPUT,
               SECOND_EVENT_PIN, FIRST_EVENT_PIN}),
        .q   (sync_q)
    );

    always_ff @(posedge MCLK)
    begin
        if (RST)
            sync_prev_reg <= 5'h00;
        else
            sync_prev_reg <= sync_q;
    end

    assign ev0_fall = sync_prev_reg[0] && !sync_q[0];
    assign ev1_fall = sync_prev_reg[1] && !sync_q[1];
    assign first_ext_irq_input_act = sync_q[2] == FIRST_IRQ_POLARITY;
    assign second_ext_irq_input_act = sync_q[3] == SECOND_IRQ_POLARITY;
    assign ext_rise = !sync_prev_reg[4] && sync_q[4];

    // ==========================================================
    // Shared prescaler
    // ==========================================================
    always_comb
    begin
        unique case (sca)
            PRE_SYS_12: pre_lim = DIV_SYS_12;
            PRE_SYS_4:  pre_lim = DIV_SYS_4;
            PRE_SYS_48: pre_lim = DIV_SYS_48;
            PRE_EXT_8:  pre_lim = DIV_SYS_12;
        endcase
    end

    // Counter wraps on >= so a shrink of the divisor never strands it
    always_ff @(posedge MCLK)
    begin
        if (RST)
            pre_cnt_reg <= 6'h00;
        else if (sca == PRE_EXT_8 || pre_cnt_reg >= pre_lim - 6'h01)
            pre_cnt_reg <= 6'h00;
        else
            pre_cnt_reg <= pre_cnt_reg + 6'h01;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            ext_cnt_reg <= 3'h0;
        else if (ext_rise)
            ext_cnt_reg <= ext_cnt_reg + 3'h1;
    end

    // External clock must stay below half of MCLK to be seen
    assign pre_tick = (sca == PRE_EXT_8)
                    ? ext_rise && ({1'b0, ext_cnt_reg} == DIV_EXT_8 - 4'h1)
                    : pre_cnt_reg >= pre_lim - 6'h01;

    // ==========================================================
    // Count enables
    // ==========================================================
    assign t0_run = tr0_reg && (!timer_mode_reg_reg[TM_FIRST_GATE] || first_ext_irq_input_act);
    assign t1_run = split ? mode1 != MODE_SPLIT
                  : tr1_reg && (!timer_mode_reg_reg[TM_SECOND_GATE] || second_ext_irq_input_act)
                    && mode1 != MODE_SPLIT;

    assign t0_inc = t0_run && (timer_mode_reg_reg[TM_FIRST_CNT] ? ev0_fall
                  : (timer_clock_control_reg[CK_FIRST_SYS] || pre_tick));
    assign t1_inc = t1_run && ((timer_mode_reg_reg[TM_SECOND_CNT] && !split) ? ev1_fall
                  : (timer_clock_control_reg[CK_SECOND_SYS] || pre_tick));
    assign th0_inc = split && tr1_reg && (timer_clock_control_reg[CK_FIRST_SYS] || pre_tick);

    function automatic dct_count_type count_step(
        input dct_mode_type mode,
        input logic [7:0]   tl,
        input logic [7:0]   th
    );
        logic [12:0] v13;
        logic [15:0] v16;
        v13 = {th, tl[4:0]} + 13'h0001;
        v16 = {th, tl} + 16'h0001;
        count_step.th  = th;
        count_step.tl  = tl + 8'h01;
        count_step.ovf = &tl;
        unique case (mode)
            MODE_13BIT:
            begin
                count_step.ovf = &{th, tl[4:0]};
                count_step.th  = v13[12:5];
                count_step.tl  = {tl[7:5], v13[4:0]};
            end
            MODE_16BIT:
            begin
                count_step.ovf = &{th, tl};
                count_step.th  = v16[15:8];
                count_step.tl  = v16[7:0];
            end
            MODE_RELOAD:
                if (&tl)
                    count_step.tl = th;
            MODE_SPLIT:
                count_step.th = th;
        endcase
    endfunction

    assign step0 = count_step(mode0, tl0_reg, th0_reg);
    assign step1 = count_step(mode1, tl1_reg, th1_reg);
    assign t1_ovf = t1_inc && step1.ovf;
    assign t0_set = t0_inc && step0.ovf;
    assign t1_set = split ? th0_inc && (&th0_reg) : t1_ovf;

    // ==========================================================
    // Count registers; a software write beats a count
    // ==========================================================
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            tl0_reg <= COUNT_RESET;
            th0_reg <= COUNT_RESET;
        end
        else
        begin
            if (t0_inc)
            begin
                tl0_reg <= step0.tl;
                th0_reg <= step0.th;
            end
            if (th0_inc)
                th0_reg <= th0_reg + 8'h01;
            if (wr_tl0)
                tl0_reg <= SFR_REQ.wdata;
            if (wr_th0)
                th0_reg <= SFR_REQ.wdata;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            tl1_reg <= COUNT_RESET;
            th1_reg <= COUNT_RESET;
        end
        else
        begin
            if (t1_inc)
            begin
                tl1_reg <= step1.tl;
                th1_reg <= step1.th;
            end
            if (wr_tl1)
                tl1_reg <= SFR_REQ.wdata;
            if (wr_th1)
                th1_reg <= SFR_REQ.wdata;
        end
    end

    // ==========================================================
    // Control, mode, clock registers and flags
    // ==========================================================
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            timer_clock_control_reg <= CLOCK_CONTROL_RESET;
            timer_mode_reg_reg  <= TIMER_MODE_RESET;
        end
        else
        begin
            if (wr_timer_clock_control)
                timer_clock_control_reg <= SFR_REQ.wdata;
            if (wr_timer_mode_reg)
                timer_mode_reg_reg <= SFR_REQ.wdata;
        end
    end

    // A hardware set wins over a software or vector clear
    always_comb
    begin
        tf0_next = wr_timer_control_reg ? SFR_REQ.wdata[TC_FIRST_OVF] : tf0_reg;
        tf1_next = wr_timer_control_reg ? SFR_REQ.wdata[TC_SECOND_OVF] : tf1_reg;
        if (FIRST_IRQ_ACK)
            tf0_next = 1'b0;
        if (SECOND_IRQ_ACK)
            tf1_next = 1'b0;
        if (t0_set)
            tf0_next = 1'b1;
        if (t1_set)
            tf1_next = 1'b1;
    end

    // Run bits touch nothing but themselves
    always_ff @(posedge MCLK)
    begin
        if (RST)
            {tf1_reg, tr1_reg, tf0_reg, tr0_reg} <= TIMER_CONTROL_RESET;
        else
        begin
            tf0_reg <= tf0_next;
            tf1_reg <= tf1_next;
            if (wr_timer_control_reg)
            begin
                tr0_reg <= SFR_REQ.wdata[TC_FIRST_RUN];
                tr1_reg <= SFR_REQ.wdata[TC_SECOND_RUN];
            end
        end
    end

    // ==========================================================
    // Outputs and read port
    // ==========================================================
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            FIRST_TIMER_IRQ        <= 1'b0;
            SECOND_TIMER_IRQ       <= 1'b0;
            SECOND_TIMER_OVF_PULSE <= 1'b0;
        end
        else
        begin
            FIRST_TIMER_IRQ        <= tf0_next && FIRST_TIMER_IRQ_ENABLE;
            SECOND_TIMER_IRQ       <= tf1_next && SECOND_TIMER_IRQ_ENABLE;
            SECOND_TIMER_OVF_PULSE <= t1_ovf;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            SFR_RDATA <= 8'h00;
        else if (SFR_REQ.rd)
        begin
            unique case (SFR_REQ.addr)
                ADDR_TIMER_CONTROL: SFR_RDATA <= {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0};
                ADDR_TIMER_MODE:    SFR_RDATA <= timer_mode_reg_reg;
                ADDR_CLOCK_CONTROL: SFR_RDATA <= timer_clock_control_reg;
                ADDR_FIRST_LOW:     SFR_RDATA <= tl0_reg;
                ADDR_FIRST_HIGH:    SFR_RDATA <= th0_reg;
                ADDR_SECOND_LOW:    SFR_RDATA <= tl1_reg;
                ADDR_SECOND_HIGH:   SFR_RDATA <= th1_reg;
                default:            SFR_RDATA <= 8'h00;
            endcase
        end
    end

    assign TIMER3_HIGH_SYSCLK_SELECT = timer_clock_control_reg[CK_T3_HIGH];
    assign TIMER3_LOW_SYSCLK_SELECT  = timer_clock_control_reg[CK_T3_LOW];
    assign TIMER2_HIGH_SYSCLK_SELECT = timer_clock_control_reg[CK_T2_HIGH];
    assign TIMER2_LOW_SYSCLK_SELECT  = timer_clock_control_reg[CK_T2_LOW];

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    logic no_wr0;
    assign no_wr0 = !wr_tl0 && !wr_th0 && !wr_timer_mode_reg && !wr_timer_control_reg;

    sequence s_div4_stable;
        pre_tick && sca == PRE_SYS_4 && !wr_timer_clock_control ##1 (sca == PRE_SYS_4 && !wr_timer_clock_control)[*3];
    endsequence

    a_div4_period: assert property (s_div4_stable |=> pre_tick)
        else $error("prescaler /4 tick missing");

    a_sysclk_count: assert property (
        t0_run && mode0 == MODE_16BIT && !timer_mode_reg_reg[TM_FIRST_CNT]
        && timer_clock_control_reg[CK_FIRST_SYS] && no_wr0
        |=> {th0_reg, tl0_reg} == $past({th0_reg, tl0_reg}) + 16'h0001)
        else $error("system clock count wrong");

    a_pin_count: assert property (
        t0_run && mode0 == MODE_16BIT && timer_mode_reg_reg[TM_FIRST_CNT] && ev0_fall && no_wr0
        |=> {th0_reg, tl0_reg} == $past({th0_reg, tl0_reg}) + 16'h0001)
        else $error("pin edge not counted");

    a_gate_hold: assert property (
        !t0_run && !split && no_wr0 |=> $stable(tl0_reg) && $stable(th0_reg))
        else $error("stopped timer moved");

    a_run_keeps: assert property (
        wr_timer_control_reg && !tr0_reg && !wr_tl0 && !wr_th0 |=> tl0_reg == $past(tl0_reg))
        else $error("run set disturbed count");

    a_wrap13_flag: assert property (
        t0_inc && mode0 == MODE_13BIT && {th0_reg, tl0_reg[4:0]} == 13'h1fff
        && no_wr0 && !FIRST_IRQ_ACK
        |=> tf0_reg && th0_reg == 8'h00 && tl0_reg[4:0] == 5'h00)
        else $error("13-bit wrap wrong");

    a_reload_copy: assert property (
        t0_inc && mode0 == MODE_RELOAD && tl0_reg == 8'hff && no_wr0
        |=> tl0_reg == $past(th0_reg) && th0_reg == $past(th0_reg) && tf0_reg)
        else $error("reload wrong");

    a_split_high: assert property (
        th0_inc && th0_reg == 8'hff && !wr_timer_control_reg && !SECOND_IRQ_ACK |=> tf1_reg)
        else $error("split high overflow lost");

    a_irq_follow: assert property (
        ##1 (tf0_reg && $past(FIRST_TIMER_IRQ_ENABLE)) |-> FIRST_TIMER_IRQ)
        else $error("interrupt request missing");

    a_ack_clear: assert property (
        FIRST_IRQ_ACK && !t0_set |=> !tf0_reg)
        else $error("vector did not clear flag");

endmodule

`default_nettype wire

// [pkg/dct_pkg.sv]
`default_nettype none

package dct_pkg;

    // ==========================================================
    // Special-function-register addresses
    // ==========================================================
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;
    localparam logic [7:0] ADDR_FIRST_LOW     = 8'h8a;
    localparam logic [7:0] ADDR_SECOND_LOW    = 8'h8b;
    localparam logic [7:0] ADDR_FIRST_HIGH    = 8'h8c;
    localparam logic [7:0] ADDR_SECOND_HIGH   = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
    localparam logic [3:0] TIMER_CONTROL_RESET = 4'h0;
    localparam logic [7:0] TIMER_MODE_RESET    = 8'h00;
    localparam logic [7:0] COUNT_RESET         = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CK_T3_HIGH    = 7;
    localparam int CK_T3_LOW     = 6;
    localparam int CK_T2_HIGH    = 5;
    localparam int CK_T2_LOW     = 4;
    localparam int CK_SECOND_SYS = 3;
    localparam int CK_FIRST_SYS  = 2;
    localparam int CK_DIV_LSB    = 0;
    localparam int TC_SECOND_OVF = 7;
    localparam int TC_SECOND_RUN = 6;
    localparam int TC_FIRST_OVF  = 5;
    localparam int TC_FIRST_RUN  = 4;
    localparam int TM_SECOND_GATE = 7;
    localparam int TM_SECOND_CNT  = 6;
    localparam int TM_SECOND_MODE = 4;
    localparam int TM_FIRST_GATE  = 3;
    localparam int TM_FIRST_CNT   = 2;
    localparam int TM_FIRST_MODE  = 0;

    // ==========================================================
    // Prescaler counts
    // ==========================================================
    localparam logic [5:0] DIV_SYS_12 = 6'h0c;
    localparam logic [5:0] DIV_SYS_4  = 6'h04;
    localparam logic [5:0] DIV_SYS_48 = 6'h30;
    localparam logic [3:0] DIV_EXT_8  = 4'h8;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dct_mode_type;

    typedef enum logic [1:0] {
        PRE_SYS_12 = 2'b00,
        PRE_SYS_4  = 2'b01,
        PRE_SYS_48 = 2'b10,
        PRE_EXT_8  = 2'b11
    } dct_presc_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dct_sfr_req_type;

    typedef struct packed {
        logic       ovf;
        logic [7:0] th;
        logic [7:0] tl;
    } dct_count_type;

endpackage

`default_nettype wire

// [testbench/dct_far_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dct_far_model (
    input  wire logic clk,
    output var  logic ev1,
    output var  logic ev2,
    output var  logic osc
);
    // ==========================================
    // Event pins idle high, oscillator free-runs
    // ==========================================
    initial
    begin
        ev1 = 1'b1;
        ev2 = 1'b1;
        osc = 1'b0;
    end

    // Toggles on falling system clock edges so sampling never races
    always #25 osc = ~osc;

    // Each level held three clocks, above the two-clock minimum
    task automatic pulse(input logic [1:0] m, input int n);
        repeat (n)
        begin
            repeat (3) @(posedge clk);
            #1;
            {ev2, ev1} = ~m;
            repeat (3) @(posedge clk);
            #1;
            {ev2, ev1} = 2'b11;
        end
    endtask
endmodule

`default_nettype wire

// [testbench/dual_counter_timer_core_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module dual_counter_timer_core_bench;
    import dct_pkg::*;
    logic            clk;
    logic            rst;
    dct_sfr_req_type req;
    logic [7:0]      rdata;
    logic            ev1;
    logic            ev2;
    logic            osc;
    logic            gin1;
    logic            gin2;
    logic            ien1;
    logic            ien2;
    logic            ack1;
    logic            ack2;
    logic            irq1;
    logic            irq2;
    logic            opls;
    logic [3:0]      sel;
    int              err_total;
    int              checked;
    int              npls = 0;
    int              np0;
    int              dv[4] = '{12, 4, 48, 80};

    dct_core u_dct_core (
        .MCLK                      (clk),
        .RST                       (rst),
        .SFR_REQ                   (req),
        .SFR_RDATA                 (rdata),
        .FIRST_EVENT_PIN           (ev1),
        .SECOND_EVENT_PIN          (ev2),
        .FIRST_EXT_IRQ_INPUT       (gin1),
        .SECOND_EXT_IRQ_INPUT      (gin2),
        .FIRST_IRQ_POLARITY        (1'b1),
        .SECOND_IRQ_POLARITY       (1'b0),
        .FIRST_TIMER_IRQ_ENABLE    (ien1),
        .SECOND_TIMER_IRQ_ENABLE   (ien2),
        .FIRST_IRQ_ACK             (ack1),
        .SECOND_IRQ_ACK            (ack2),
        .EXT_OSC_CLK               (osc),
        .FIRST_TIMER_IRQ           (irq1),
        .SECOND_TIMER_IRQ          (irq2),
        .SECOND_TIMER_OVF_PULSE    (opls),
        .TIMER3_HIGH_SYSCLK_SELECT (sel[3]),
        .TIMER3_LOW_SYSCLK_SELECT  (sel[2]),
        .TIMER2_HIGH_SYSCLK_SELECT (sel[1]),
        .TIMER2_LOW_SYSCLK_SELECT  (sel[0])
    );

    dct_far_model u_dct_far_model (
        .clk (clk),
        .ev1 (ev1),
        .ev2 (ev2),
        .osc (osc)
    );

    always #2.5 clk = ~clk;

    always @(posedge clk)
    begin
        if (opls === 1'b1)
            npls <= npls + 1;
    end

    // ==========================================
    // Bus and compare tasks
    // ==========================================
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = {1'b1, 1'b0, a, d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
        req = {1'b0, 1'b1, a, 8'h00};
        cyc(1);
        req = '0;
        chk8(rdata & m, e);
        cyc(1);
    endtask

    // Counts n+2 enabled edges between the two control writes
    task automatic run(input logic [7:0] c, input int n);
        wr(ADDR_TIMER_CONTROL, c);
        cyc(n);
        wr(ADDR_TIMER_CONTROL, 8'h00);
    endtask

    task automatic clr();
        for (int k = 0; k < 4; k++)
            wr(ADDR_FIRST_LOW + 8'(k), 8'h00);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_total++;
        conclude();
    end

    // ==========================================
    // Tests
    // ==========================================
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        {gin1, gin2, ien1, ien2, ack1, ack2} = 6'b010000;
        err_total = 0;
        checked = 0;
        cyc(6);
        rst = 1'b0;
        rd(ADDR_CLOCK_CONTROL, CLOCK_CONTROL_RESET);
        rd(ADDR_TIMER_CONTROL, 8'h00);
        rd(8'h90, 8'h00);
        wr(ADDR_CLOCK_CONTROL, 8'hf0);
        rd(ADDR_CLOCK_CONTROL, 8'hf0);
        chk8({4'h0, sel}, 8'h0f);
        wr(ADDR_CLOCK_CONTROL, 8'ha4);
        chk8({4'h0, sel}, 8'h0a);
        $display("registers done");
        wr(ADDR_TIMER_MODE, 8'h01);
        wr(ADDR_FIRST_HIGH, 8'h12);
        wr(ADDR_FIRST_LOW, 8'hfe);
        run(8'h10, 3);
        rd(ADDR_FIRST_LOW, 8'h03);
        rd(ADDR_FIRST_HIGH, 8'h13);
        run(8'h10, 0);
        rd(ADDR_FIRST_LOW, 8'h05);
        $display("sixteen bit done");
        foreach (dv[i])
        begin
            wr(ADDR_CLOCK_CONTROL, 8'(i));
            clr();
            run(8'h10, 3 * dv[i] - 2);
            rd(ADDR_FIRST_LOW, 8'h03);
        end
        $display("prescaler done");
        wr(ADDR_CLOCK_CONTROL, 8'h00);
        wr(ADDR_TIMER_MODE, 8'h55);
        clr();
        wr(ADDR_TIMER_CONTROL, 8'h50);
        u_dct_far_model.pulse(2'b11, 3);
        u_dct_far_model.pulse(2'b01, 2);
        cyc(6);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_FIRST_LOW, 8'h05);
        rd(ADDR_SECOND_LOW, 8'h03);
        wr(ADDR_TIMER_MODE, 8'hdd);
        clr();
        wr(ADDR_TIMER_CONTROL, 8'h50);
        u_dct_far_model.pulse(2'b11, 2);
        {gin1, gin2} = 2'b10;
        cyc(4);
        u_dct_far_model.pulse(2'b11, 4);
        cyc(6);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_FIRST_LOW, 8'h04);
        rd(ADDR_SECOND_LOW, 8'h04);
        $display("events done");
        wr(ADDR_CLOCK_CONTROL, 8'h04);
        wr(ADDR_TIMER_MODE, 8'h00);
        wr(ADDR_FIRST_HIGH, 8'hff);
        wr(ADDR_FIRST_LOW, 8'h1f);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        rd(ADDR_TIMER_CONTROL, 8'h30);
        wr(ADDR_TIMER_CONTROL, 8'h20);
        rd(ADDR_FIRST_LOW, 8'h03, 8'h1f);
        rd(ADDR_FIRST_HIGH, 8'h00);
        chk8({7'h0, irq1}, 8'h00);
        ien1 = 1'b1;
        cyc(2);
        chk8({7'h0, irq1}, 8'h01);
        ack1 = 1'b1;
        cyc(1);
        ack1 = 1'b0;
        cyc(1);
        chk8({7'h0, irq1}, 8'h00);
        rd(ADDR_TIMER_CONTROL, 8'h00);
        $display("thirteen bit done");
        wr(ADDR_CLOCK_CONTROL, 8'h08);
        wr(ADDR_TIMER_MODE, 8'h20);
        wr(ADDR_SECOND_LOW, 8'hfe);
        wr(ADDR_SECOND_HIGH, 8'h80);
        ien2 = 1'b1;
        np0 = npls;
        wr(ADDR_TIMER_CONTROL, 8'h40);
        cyc(1);
        rd(ADDR_TIMER_CONTROL, 8'hc0);
        chk8({7'h0, irq2}, 8'h01);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_SECOND_LOW, 8'h83);
        rd(ADDR_SECOND_HIGH, 8'h80);
        chk8(8'(npls - np0), 8'h01);
        $display("reload done");
        wr(ADDR_CLOCK_CONTROL, 8'h04);
        wr(ADDR_TIMER_MODE, 8'h03);
        clr();
        wr(ADDR_FIRST_HIGH, 8'hff);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        cyc(1);
        rd(ADDR_TIMER_CONTROL, 8'hc0);
        wr(ADDR_TIMER_CONTROL, 8'h80);
        chk8({7'h0, irq2}, 8'h01);
        rd(ADDR_FIRST_HIGH, 8'h04);
        rd(ADDR_FIRST_LOW, 8'h00);
        ack2 = 1'b1;
        cyc(1);
        ack2 = 1'b0;
        cyc(1);
        chk8({7'h0, irq2}, 8'h00);
        rd(ADDR_TIMER_CONTROL, 8'h00);
        wr(ADDR_CLOCK_CONTROL, 8'h0c);
        wr(ADDR_TIMER_MODE, 8'h33);
        clr();
        cyc(4);
        rd(ADDR_SECOND_LOW, 8'h00);
        wr(ADDR_TIMER_MODE, 8'h53);
        rd(ADDR_SECOND_LOW, 8'h01);
        $display("split done");
        conclude();
    end
endmodule

`default_nettype wire
